/* bench/fault_mgr_sva.sv */
// Concurrent checks on the fault manager ports
`timescale 1ns/1ns
module fault_mgr_sva
  import fault_mgr_pkg::*;
#(
  parameter int unsigned SLEEP_CYC = SLEEP_TIMEOUT_CYC
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Inputs watched
  input wire logic core_supply_low,
  input wire logic drain_source_trip_level,
  input wire logic regulator_current_limit,
  input wire logic regulator_overcurrent_trip,
  input wire logic enable_pin,
  input wire logic clear_fault_bit,
  input wire logic rails_ready,
  input wire logic [1:0] drain_trip_resp,
  input wire logic [RETRY_W-1:0] drain_trip_retry_delay,
  // Outputs watched
  input wire logic [1:0] mode,
  input wire logic driver_block,
  input wire logic regulator_hiccup,
  input wire logic pump_off,
  input wire logic core_logic_off,
  input wire logic fault_out_n_oe,
  input wire logic [ST_W-1:0] status
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [CNT_W-1:0] low_cnt_ff;
  logic [CNT_W-1:0] nxt_low_cnt;
  logic active;
  assign active = mode == MODE_OPERATE || mode == MODE_FAULT;
  // Saturates so a very long low level cannot wrap back to zero
  assign nxt_low_cnt = enable_pin ? '0 :
    (&low_cnt_ff ? low_cnt_ff : low_cnt_ff + 1'b1);
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      low_cnt_ff <= '0;
    else
      low_cnt_ff <= nxt_low_cnt;
  end
  sequence drain_held(logic [1:0] r);
    (drain_source_trip_level && drain_trip_resp == r && active)[*4];
  endsequence
  sequence quiet_pin;
    (status == '0 && !fault_out_n_oe && rails_ready &&
      mode == MODE_OPERATE)[*8];
  endsequence
  core_shut_a: assert property (core_supply_low |=>
    mode == MODE_SHUTDOWN && driver_block && core_logic_off)
    else $error("core supply low did not shut down");
  drain_latch_a: assert property (drain_held(OC_LATCH) |=>
    status[ST_DRAIN] && driver_block && mode == MODE_FAULT)
    else $error("drain trip not latched");
  status_only_a: assert property (drain_held(OC_STATUS) ##0
    (status == (ST_W'(1) << ST_DRAIN) && mode == MODE_OPERATE)
    |=> !driver_block) else $error("status-only trip blocked driver");
  retry_release_a: assert property (drain_trip_resp == OC_RETRY &&
    drain_trip_retry_delay <= 20 && $fell(drain_source_trip_level)
    |-> ##[1:40] !status[ST_DRAIN]) else $error("retry never released");
  clear_status_a: assert property ((!drain_source_trip_level)[*4]
    ##0 clear_fault_bit |=> !status[ST_DRAIN])
    else $error("clear left drain status set");
  pin_deglitch_a: assert property (quiet_pin |=>
    (!fault_out_n_oe)[*8]) else $error("fault pin moved without deglitch");
  pin_follow_a: assert property ($rose(status[ST_DRAIN]) &&
    drain_trip_resp inside {OC_LATCH, OC_REPORT}
    |-> ##[20:40] fault_out_n_oe) else $error("fault pin not pulled");
  reg_trip_a: assert property (regulator_overcurrent_trip[*4]
    ##0 active |=> driver_block && regulator_hiccup && pump_off &&
    status[ST_REG_OC]) else $error("regulator trip not handled");
  limit_silent_a: assert property ((regulator_current_limit &&
    !driver_block && status == '0)[*4] |=> !driver_block && status == '0)
    else $error("current limit touched driver or status");
  sleep_force_a: assert property (low_cnt_ff == SLEEP_CYC + 8 &&
    !core_supply_low |-> mode == MODE_SLEEP)
    else $error("long enable low did not force sleep");
endmodule
bind gate_driver_fault_manager fault_mgr_sva #(.SLEEP_CYC(SLEEP_CYC)) chk_i (
  .core_clk, .nrst, .core_supply_low, .drain_source_trip_level,
  .regulator_current_limit, .regulator_overcurrent_trip, .enable_pin,
  .clear_fault_bit, .rails_ready, .drain_trip_resp, .drain_trip_retry_delay,
  .mode, .driver_block, .regulator_hiccup, .pump_off, .core_logic_off,
  .fault_out_n_oe, .status);

/* bench/host_mcu_model.sv */
// Host controller model: drives enable and reads the fault line
`timescale 1ns/1ns
module host_mcu_model
  import fault_mgr_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Fault pin, open drain with a board pull-up
  input wire logic fault_out_n_oe,
  output logic fault_line,
  // Host enable
  output logic enable_pin
);
  initial enable_pin = 1'b1;
  // Pull-up wins whenever nobody sinks the line
  assign fault_line = fault_out_n_oe ? 1'b0 : 1'b1;
  task automatic drive(input logic v);
    @(posedge core_clk);
    enable_pin <= v;
  endtask
  // Width clamped so a recovery pulse never becomes a sleep request at the default SLEEP_TIMEOUT_CYC
  task automatic en_low(input int n);
    drive(1'b0);
    repeat (n < EN_PULSE_MIN_CYC ? EN_PULSE_MIN_CYC :
      (n > EN_PULSE_MAX_CYC ? EN_PULSE_MAX_CYC : n)) @(posedge core_clk);
    enable_pin <= 1'b1;
  endtask
endmodule

/* bench/tb_gate_driver_fault_manager.sv */
// Self-checking bench for the gate driver fault manager
`timescale 1ns/1ns
module tb_gate_driver_fault_manager;
  import fault_mgr_pkg::*;
  localparam int unsigned SLP = 400;
  logic core_clk, nrst, core_supply_low, clear_fault_bit;
  logic pump_report_only, warn_status_only, rails_ready;
  logic [9:0] flt;
  logic [1:0] drain_trip_resp, shunt_trip_resp, mode;
  logic [RETRY_W-1:0] drain_trip_retry_delay, shunt_trip_retry_delay;
  logic driver_block, regulator_hiccup, regulator_off, pump_off;
  logic core_logic_off, rail_restart, fault_out_n_o, fault_out_n_oe;
  logic enable_pin, fault_line;
  logic [ST_W-1:0] status;
  logic [5:0] ocx [4] = '{6'b011111, 6'b011000, 6'b001011, 6'b000001};
  int errors = 0;
  int n_compared = 0;
  gate_driver_fault_manager #(.SLEEP_CYC(SLP)) uut (
    .core_clk, .nrst, .core_supply_low,
    .motor_supply_low_level(flt[0]), .pump_low_level(flt[1]),
    .drain_source_trip_level(flt[2]), .shunt_trip_level(flt[3]),
    .overheat_warning(flt[4]), .overheat_shutdown(flt[5]),
    .regulator_overcurrent_trip(flt[6]), .regulator_under(flt[7]),
    .regulator_over(flt[8]), .regulator_current_limit(flt[9]),
    .enable_pin, .clear_fault_bit, .pump_report_only, .drain_trip_resp,
    .shunt_trip_resp, .warn_status_only, .drain_trip_retry_delay,
    .shunt_trip_retry_delay, .rails_ready, .mode, .driver_block,
    .regulator_hiccup, .regulator_off, .pump_off, .core_logic_off,
    .rail_restart, .fault_out_n_o, .fault_out_n_oe, .status);
  host_mcu_model host (.core_clk, .fault_out_n_oe, .fault_line, .enable_pin);
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Rails come back one cycle after a restart request drops
  always @(posedge core_clk) rails_ready <= !rail_restart;
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic settle();
    @(negedge core_clk);
  endtask
  task automatic chk(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t %s got %b", $time, what, got);
    end
  endtask
  task automatic clear();
    @(posedge core_clk);
    clear_fault_bit <= 1'b1;
    @(posedge core_clk);
    clear_fault_bit <= 1'b0;
  endtask
  // ex: enable recovery, block/pin while on, block/pin/status after removal
  task automatic run(input int i, input logic [1:0] cfg, input logic [5:0] ex);
    @(posedge core_clk);
    drain_trip_resp <= cfg;
    shunt_trip_resp <= cfg;
    pump_report_only <= cfg[0];
    warn_status_only <= cfg[0];
    cyc(2);
    flt[i] <= 1'b1;
    cyc(40);
    settle();
    chk(i < 9 ? status[i] : |status, 1'(i < 9), "set");
    chk(driver_block, ex[4], "block");
    chk(fault_line, !ex[3], "pin");
    if (i == 0)
      chk(rail_restart, 1'b1, "restart");
    if (i == 6)
      chk(regulator_hiccup && pump_off, 1'b1, "trip");
    if (i == 7 || i == 8)
      chk(i == 7 ? regulator_hiccup : regulator_off, 1'b1, "rail");
    @(posedge core_clk);
    flt[i] <= 1'b0;
    cyc(80);
    settle();
    chk(driver_block, ex[2], "held block");
    chk(fault_line, !ex[1], "held pin");
    chk(i < 9 ? status[i] : 1'b0, ex[0], "held status");
    if (ex[5])
      host.en_low(300);
    else
      clear();
    cyc(60);
    settle();
    chk(driver_block || status != '0, 1'b0, "cleared");
    chk(fault_line, 1'b1, "released");
    chk(mode === MODE_OPERATE, 1'b1, "mode");
  endtask
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #(40 * 20000);
    errors++;
    $display("ERROR %0t watchdog", $time);
    give_verdict();
  end
  initial
  begin
    nrst = 1'b0;
    {core_supply_low, clear_fault_bit, pump_report_only, warn_status_only,
      flt, drain_trip_resp, shunt_trip_resp} = '0;
    drain_trip_retry_delay = 20;
    shunt_trip_retry_delay = 20;
    cyc(5);
    nrst <= 1'b1;
    cyc(100);
    settle();
    chk(mode === MODE_OPERATE, 1'b1, "up mode");
    chk(fault_line, 1'b1, "up pin");
    chk(fault_out_n_o, 1'b0, "pin level");
    for (int j = 2; j < 4; j++)
      for (int k = 0; k < 4; k++)
        run(j, 2'(k), ocx[k]);
    run(0, 2'd0, 6'b011000);
    run(1, 2'd0, 6'b111101);
    run(1, 2'd1, 6'b001011);
    run(4, 2'd0, 6'b001000);
    run(4, 2'd1, 6'b000000);
    for (int j = 5; j < 9; j++)
      run(j, 2'd0, 6'b011101);
    run(9, 2'd0, 6'b000000);
    host.drive(1'b0);
    flt[5] <= 1'b1;
    cyc(SLP + 40);
    settle();
    chk(mode === MODE_SLEEP, 1'b1, "sleep");
    @(posedge core_clk);
    flt[5] <= 1'b0;
    host.drive(1'b1);
    cyc(40);
    clear();
    cyc(200);
    settle();
    chk(mode === MODE_OPERATE, 1'b1, "wake");
    @(posedge core_clk);
    core_supply_low <= 1'b1;
    cyc(2);
    settle();
    chk(mode === MODE_SHUTDOWN && driver_block && core_logic_off, 1'b1,
      "shut");
    @(posedge core_clk);
    core_supply_low <= 1'b0;
    cyc(1);
    settle();
    chk(mode === MODE_SLEEP, 1'b1, "after shut");
    give_verdict();
  end
endmodule

/* rtl/fault_mgr_pkg.sv */
// Constants and types for the gate driver fault manager
package fault_mgr_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  // Times in nanoseconds as printed
  localparam int unsigned SLEEP_TIMEOUT_NS = 1000000;
  localparam int unsigned EN_PULSE_MIN_NS = 10000;
  localparam int unsigned EN_PULSE_MAX_NS = 200000;
  localparam int unsigned DEGLITCH_NS = 1000;
  localparam int unsigned CLK_PERIOD_NS = 1000000000 / CLK_HZ;
  // Sleep timeout and least enable pulse round up; longest pulse and deglitch round down
  localparam int unsigned SLEEP_TIMEOUT_CYC =
    (SLEEP_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EN_PULSE_MIN_CYC =
    (EN_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EN_PULSE_MAX_CYC = EN_PULSE_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned DEGLITCH_CYC = DEGLITCH_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned RETRY_W = 20;
  // Overcurrent response codes
  typedef enum logic [1:0] {
    OC_LATCH = 2'b00,
    OC_RETRY = 2'b01,
    OC_REPORT = 2'b10,
    OC_STATUS = 2'b11
  } oc_resp_e;
  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_OPERATE = 2'b10,
    MODE_FAULT = 2'b11
  } mode_e;
  // Status bit positions
  localparam int unsigned ST_MOTOR = 0;
  localparam int unsigned ST_PUMP = 1;
  localparam int unsigned ST_DRAIN = 2;
  localparam int unsigned ST_SHUNT = 3;
  localparam int unsigned ST_WARN = 4;
  localparam int unsigned ST_THERM = 5;
  localparam int unsigned ST_REG_OC = 6;
  localparam int unsigned ST_REG_UV = 7;
  localparam int unsigned ST_REG_OV = 8;
  localparam int unsigned ST_W = 9;
  localparam int unsigned N_FLT = 10;
  localparam logic [ST_W-1:0] STATUS_RST = 9'h000;
endpackage

/* rtl/gate_driver_fault_manager.sv */
// Fault manager for a three-phase gate driver
// Notes on behaviour
// - Core supply low: shutdown, block, low gates
// - Motor supply low: fault mode, pin, status
// - Motor supply recovery waits rail soft-start
// - Pump low by default latches driver block
// - Pump low report-only keeps driver running
// - Latched block clears on enable pulse/clear
// - Full latch holds pin, block, status together
// - Drain overcurrent has four selectable responses
// - Shunt overcurrent has same four responses
// - Retry holds block until delay expires
// - Report-only pin needs clear and removal
// - Overheat warning pulls pin, clears itself
// - Warning status-only leaves pin untouched
// - Regulator limit silent; trip blocks, hiccups
// - Regulator under/over voltage blocks driver
// - Long enable low forces sleep mode
// - Comparators carry hysteresis, flags do not chatter
// - Fault pin low while any fault present, except status-only ones, regulator limit and core supply low
// - Pin latches for overcurrent until cleared; retry releases it after the delay
// - Fault pin changes pass a deglitch, except at entry to or exit from shutdown
// - Pin high only after rails settle
`timescale 1ns/1ns
module gate_driver_fault_manager
  import fault_mgr_pkg::*;
#(
  parameter int unsigned SLEEP_CYC = SLEEP_TIMEOUT_CYC
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Comparator fault levels, hysteresis applied in the analog front end
  input wire logic core_supply_low,
  input wire logic motor_supply_low_level,
  input wire logic pump_low_level,
  input wire logic drain_source_trip_level,
  input wire logic shunt_trip_level,
  input wire logic overheat_warning,
  input wire logic overheat_shutdown,
  input wire logic regulator_current_limit,
  input wire logic regulator_overcurrent_trip,
  input wire logic regulator_under,
  input wire logic regulator_over,
  // Host enable pin
  input wire logic enable_pin,
  // Configuration and commands from the same clock domain
  input wire logic clear_fault_bit,
  input wire logic pump_report_only,
  input wire logic [1:0] drain_trip_resp,
  input wire logic [1:0] shunt_trip_resp,
  input wire logic warn_status_only,
  input wire logic [RETRY_W-1:0] drain_trip_retry_delay,
  input wire logic [RETRY_W-1:0] shunt_trip_retry_delay,
  input wire logic rails_ready,
  // Mode and power control
  output logic [1:0] mode,
  output logic driver_block,
  output logic regulator_hiccup,
  output logic regulator_off,
  output logic pump_off,
  output logic core_logic_off,
  output logic rail_restart,
  // Fault pin, open drain
  output logic fault_out_n_o,
  output logic fault_out_n_oe,
  // Status
  output logic [ST_W-1:0] status
);

  initial
  begin
    if (SLEEP_CYC < 2 || SLEEP_CYC >= (1 << 20))
      $error("SLEEP_CYC out of range");
    if (DEGLITCH_CYC < 1 || EN_PULSE_MIN_CYC >= (1 << CNT_W))
      $error("cycle constants out of range");
  end

  typedef struct packed {
    logic [N_FLT-1:0] sync1;
    logic [N_FLT-1:0] sync2;
    logic en1;
    logic en2;
    logic en_d;
    logic [19:0] en_low_cnt;
    logic clr_evt;
    mode_e mode;
    logic latch_blk;
    logic [ST_W-1:0] status;
    logic drain_pin;
    logic shunt_pin;
    logic pump_pin;
    logic [RETRY_W-1:0] drain_retry;
    logic [RETRY_W-1:0] shunt_retry;
    logic drain_wait;
    logic shunt_wait;
    logic pin_raw;
    logic [CNT_W-1:0] dg_cnt;
    logic pin_low;
    logic powered;
  } state_s;

  state_s cur_ff;
  state_s nxt_ff;

  logic [N_FLT-1:0] raw;
  assign raw = {regulator_current_limit, regulator_over, regulator_under,
                regulator_overcurrent_trip, overheat_shutdown,
                overheat_warning, shunt_trip_level,
                drain_source_trip_level, pump_low_level,
                motor_supply_low_level};

  // Blocking faults for one overcurrent source under a response code
  function automatic logic oc_blocks(input logic [1:0] r);
    oc_blocks = (r == OC_LATCH) || (r == OC_RETRY);
  endfunction

  function automatic logic oc_pins(input logic [1:0] r);
    oc_pins = (r != OC_STATUS);
  endfunction

  always_comb
  begin
    logic [N_FLT-1:0] f;
    logic core_low;
    logic en_rise;
    logic clr;
    logic sleep_force;
    logic motor_f;
    logic hard_f;
    logic live_pin;
    logic drain_go;
    logic shunt_go;
    f = cur_ff.sync2;
    core_low = core_supply_low;
    en_rise = 1'b0;
    clr = 1'b0;
    sleep_force = 1'b0;
    motor_f = 1'b0;
    hard_f = 1'b0;
    live_pin = 1'b0;
    drain_go = 1'b0;
    shunt_go = 1'b0;
    nxt_ff = cur_ff;
    nxt_ff.sync1 = raw;
    nxt_ff.sync2 = cur_ff.sync1;
    nxt_ff.en1 = enable_pin;
    nxt_ff.en2 = cur_ff.en1;
    nxt_ff.en_d = cur_ff.en2;
    // Enable low counter; saturates so a long low is seen once
    if (!cur_ff.en2)
    begin
      if (cur_ff.en_low_cnt != 20'hfffff)
        nxt_ff.en_low_cnt = cur_ff.en_low_cnt + 20'h00001;
    end
    else
      nxt_ff.en_low_cnt = 20'h00000;
    sleep_force = !cur_ff.en2 && (cur_ff.en_low_cnt >= SLEEP_CYC[19:0]);
    // Too short a pulse is a glitch and is ignored; host keeps it legal
    en_rise = cur_ff.en2 && !cur_ff.en_d &&
              (cur_ff.en_low_cnt >= EN_PULSE_MIN_CYC[19:0]);
    clr = en_rise || clear_fault_bit;
    nxt_ff.clr_evt = clr;
    motor_f = f[ST_MOTOR];
    // Latched-driver faults
    hard_f = f[ST_THERM] || f[ST_REG_OC] || f[ST_REG_UV] || f[ST_REG_OV] ||
             (f[ST_PUMP] && !pump_report_only);
    // Status: clear first, then set wins over the clear
    if (clr)
      nxt_ff.status = STATUS_RST;
    if (f[ST_MOTOR]) nxt_ff.status[ST_MOTOR] = 1'b1;
    if (f[ST_PUMP]) nxt_ff.status[ST_PUMP] = 1'b1;
    if (f[ST_DRAIN]) nxt_ff.status[ST_DRAIN] = 1'b1;
    if (f[ST_SHUNT]) nxt_ff.status[ST_SHUNT] = 1'b1;
    if (f[ST_THERM]) nxt_ff.status[ST_THERM] = 1'b1;
    if (f[ST_REG_OC]) nxt_ff.status[ST_REG_OC] = 1'b1;
    if (f[ST_REG_UV]) nxt_ff.status[ST_REG_UV] = 1'b1;
    if (f[ST_REG_OV]) nxt_ff.status[ST_REG_OV] = 1'b1;
    // Warning tracks its comparator once rails are up and no hard or motor supply fault is present
    if (f[ST_WARN])
      nxt_ff.status[ST_WARN] = 1'b1;
    else if (rails_ready && !hard_f && !motor_f)
      nxt_ff.status[ST_WARN] = 1'b0;
    // Motor supply low status recovers by itself
    if (!f[ST_MOTOR] && rails_ready)
      nxt_ff.status[ST_MOTOR] = 1'b0;
    // Latched driver block
    if (hard_f)
      nxt_ff.latch_blk = 1'b1;
    else if (clr)
      nxt_ff.latch_blk = 1'b0;
    // Drain overcurrent
    drain_go = f[ST_DRAIN] && oc_pins(drain_trip_resp);
    if (drain_go)
      nxt_ff.drain_pin = 1'b1;
    else if (drain_trip_resp == OC_REPORT && clr)
      nxt_ff.drain_pin = 1'b0;
    else if (drain_trip_resp == OC_LATCH && clr)
      nxt_ff.drain_pin = 1'b0;
    if (f[ST_DRAIN] && drain_trip_resp == OC_RETRY)
    begin
      nxt_ff.drain_wait = 1'b1;
      nxt_ff.drain_retry = drain_trip_retry_delay;
    end
    else if (cur_ff.drain_wait)
    begin
      if (cur_ff.drain_retry == '0)
      begin
        nxt_ff.drain_wait = 1'b0;
        nxt_ff.drain_pin = 1'b0;
        nxt_ff.status[ST_DRAIN] = 1'b0;
      end
      else
        nxt_ff.drain_retry = cur_ff.drain_retry - 1'b1;
    end
    // Shunt overcurrent
    shunt_go = f[ST_SHUNT] && oc_pins(shunt_trip_resp);
    if (shunt_go)
      nxt_ff.shunt_pin = 1'b1;
    else if (shunt_trip_resp != OC_RETRY && clr)
      nxt_ff.shunt_pin = 1'b0;
    if (f[ST_SHUNT] && shunt_trip_resp == OC_RETRY)
    begin
      nxt_ff.shunt_wait = 1'b1;
      nxt_ff.shunt_retry = shunt_trip_retry_delay;
    end
    else if (cur_ff.shunt_wait)
    begin
      if (cur_ff.shunt_retry == '0)
      begin
        nxt_ff.shunt_wait = 1'b0;
        nxt_ff.shunt_pin = 1'b0;
        nxt_ff.status[ST_SHUNT] = 1'b0;
      end
      else
        nxt_ff.shunt_retry = cur_ff.shunt_retry - 1'b1;
    end
    // Pump report-only holds the pin until cleared after removal
    if (f[ST_PUMP] && pump_report_only)
      nxt_ff.pump_pin = 1'b1;
    else if (clr)
      nxt_ff.pump_pin = 1'b0;
    // Full-latch overcurrent also holds the driver block
    if ((f[ST_DRAIN] && drain_trip_resp == OC_LATCH) ||
        (f[ST_SHUNT] && shunt_trip_resp == OC_LATCH))
      nxt_ff.latch_blk = 1'b1;
    // Mode
    if (core_low)
      nxt_ff.mode = MODE_SHUTDOWN;
    else if (sleep_force)
      nxt_ff.mode = MODE_SLEEP;
    else if (cur_ff.mode == MODE_SHUTDOWN)
      nxt_ff.mode = MODE_SLEEP;
    else if (motor_f || hard_f || nxt_ff.latch_blk ||
             nxt_ff.drain_wait || nxt_ff.shunt_wait)
      nxt_ff.mode = MODE_FAULT;
    else if (cur_ff.en2 && rails_ready)
      nxt_ff.mode = MODE_OPERATE;
    else if (cur_ff.mode == MODE_FAULT)
      nxt_ff.mode = MODE_FAULT;
    else
      nxt_ff.mode = cur_ff.mode;
    if (nxt_ff.mode == MODE_OPERATE && rails_ready && cur_ff.en2)
      nxt_ff.powered = 1'b1;
    else if (nxt_ff.mode == MODE_SHUTDOWN || nxt_ff.mode == MODE_SLEEP)
      nxt_ff.powered = 1'b0;
    // Fault pin request; warning only unless status-only
    live_pin = motor_f || hard_f || (f[ST_PUMP] && !pump_report_only) ||
               (f[ST_WARN] && !warn_status_only) || !rails_ready ||
               cur_ff.status[ST_WARN] && !warn_status_only;
    nxt_ff.pin_raw = live_pin || cur_ff.drain_pin || cur_ff.shunt_pin ||
                     cur_ff.pump_pin || !cur_ff.powered;
    // Deglitch: pin follows a request only after it holds steady
    if (cur_ff.pin_raw == cur_ff.pin_low)
      nxt_ff.dg_cnt = '0;
    else if (cur_ff.dg_cnt >= DEGLITCH_CYC[CNT_W-1:0] - 1'b1)
    begin
      nxt_ff.pin_low = cur_ff.pin_raw;
      nxt_ff.dg_cnt = '0;
    end
    else
      nxt_ff.dg_cnt = cur_ff.dg_cnt + 1'b1;
    // Sleep and shutdown drop the block latch and retry waits; core supply loss wins over all
    if (nxt_ff.mode == MODE_SHUTDOWN || nxt_ff.mode == MODE_SLEEP)
    begin
      nxt_ff.latch_blk = 1'b0;
      nxt_ff.drain_wait = 1'b0;
      nxt_ff.shunt_wait = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cur_ff <= '0;
      cur_ff.mode <= MODE_SHUTDOWN;
      cur_ff.pin_raw <= 1'b1;
      cur_ff.pin_low <= 1'b1;
      cur_ff.status <= STATUS_RST;
    end
    else
      cur_ff <= nxt_ff;
  end

  // Hysteresis sits in the comparators; logic only adds the deglitch
  assign mode = cur_ff.mode;
  assign driver_block = (cur_ff.mode != MODE_OPERATE) ||
                        cur_ff.latch_blk || cur_ff.drain_wait ||
                        cur_ff.shunt_wait;
  assign regulator_hiccup = cur_ff.sync2[ST_REG_OC] ||
                            cur_ff.sync2[ST_REG_UV];
  assign regulator_off = cur_ff.sync2[ST_REG_OV] ||
                         cur_ff.mode == MODE_SHUTDOWN ||
                         cur_ff.mode == MODE_SLEEP;
  assign pump_off = regulator_off || regulator_hiccup ||
                    cur_ff.sync2[ST_THERM] || cur_ff.sync2[ST_MOTOR];
  assign core_logic_off = (cur_ff.mode == MODE_SHUTDOWN);
  // Motor supply loss re-runs rail soft-start before operate returns
  assign rail_restart = cur_ff.mode == MODE_FAULT &&
                        cur_ff.sync2[ST_MOTOR];
  assign fault_out_n_o = 1'b0;
  // Pin released in shutdown since core logic is off
  assign fault_out_n_oe = cur_ff.pin_low && (cur_ff.mode != MODE_SHUTDOWN);
  assign status = cur_ff.status;

endmodule
